// file: inc/smcd_defines.svh
`ifndef SMCD_DEFINES_SVH
`define SMCD_DEFINES_SVH

`define SMCD_CMD_WR_CFG    8'h01
`define SMCD_CMD_RD_CFG    8'h02
`define SMCD_CMD_RD_CV     8'h04
`define SMCD_CMD_RD_FLG    8'h06
`define SMCD_CMD_RD_TMP    8'h08
`define SMCD_CMD_POLL_ADC  8'h40
`define SMCD_CMD_POLL_INT  8'h50

`define SMCD_FAM_CELL      4'h1
`define SMCD_FAM_OW        4'h2
`define SMCD_FAM_TEMP      4'h3
`define SMCD_FAM_CELL_DC   4'h6
`define SMCD_FAM_OW_DC     4'h7

`define SMCD_SUB_CELL11    4'hb
`define SMCD_SUB_CELL12    4'hc
`define SMCD_SUB_UNUSED    4'hd
`define SMCD_SUB_TEST1     4'he
`define SMCD_SUB_TEST2     4'hf
`define SMCD_SUB_TEMP_LAST 4'h3

`define SMCD_PAT1          12'h555
`define SMCD_PAT2          12'haaa

`define SMCD_CFG_BYTES     5'd6
`define SMCD_CV_BYTES      5'd18
`define SMCD_CV10_BYTES    5'd15
`define SMCD_FLG_BYTES     5'd3
`define SMCD_TMP_BYTES     5
`define SMCD_NUM_CELLS     12
`define SMCD_NUM_PAIRS     6

`define SMCD_CFG_RESET     8'h00
`define SMCD_CFG_TEN_BIT   3
`define SMCD_CFG_LVL_BIT   4
`define SMCD_DCC_HI        3:0
`define SMCD_CV_LO_BYTE    7:0
`define SMCD_CV_HI_NIB     11:8
`define SMCD_CV_LO_NIB     3:0
`define SMCD_CV_HI_BYTE    11:4
`define SMCD_TMP_KEEP      7:4

`define SMCD_CRC_POLY      8'h07
`define SMCD_CRC_INIT      8'h00

`define SMCD_PIN_IDLE      5'h1f
`define SMCD_TOGGLE_HALF_US 500
`define SMCD_CLK_MHZ       50

`endif

// file: inc/smcd_pkg.sv
package smcd_pkg;
  typedef enum logic [4:0] {
    SMCD_ST_IDLE  = 5'b00001,
    SMCD_ST_WRITE = 5'b00010,
    SMCD_ST_READ  = 5'b00100,
    SMCD_ST_POLL  = 5'b01000,
    SMCD_ST_SKIP  = 5'b10000
  } smcd_state_t;

  typedef enum logic [1:0] {
    SMCD_G_CFG,
    SMCD_G_CV,
    SMCD_G_FLG,
    SMCD_G_TMP
  } smcd_grp_t;

  typedef enum logic [1:0] {
    SMCD_T_NONE,
    SMCD_T_PAT1,
    SMCD_T_PAT2
  } smcd_tst_t;
endpackage

// file: inc/smcd_link_if.sv
`timescale 1ns/1ps
interface smcd_link_if;
  logic sck_lvl;
  logic sck_rise;
  logic sck_fall;
  logic cs_act;
  logic cs_rise;
  logic sdi;
  logic sdo_up;
  logic tos;

  modport front (output sck_lvl, sck_rise, sck_fall, cs_act, cs_rise,
                 output sdi, sdo_up, tos);
  modport core  (input  sck_lvl, sck_rise, sck_fall, cs_act, cs_rise,
                 input  sdi, sdo_up, tos);
endinterface

// file: rtl/smcd_link_sync.sv
`timescale 1ns/1ps
`include "smcd_defines.svh"
module smcd_link_sync (
  input  wire logic  mclk_i,
  input  wire logic  rst_n_i,
  input  wire logic  sck_i,
  input  wire logic  csb_n_i,
  input  wire logic  sdi_i,
  input  wire logic  sdo_up_i,
  input  wire logic  tos_i,
  smcd_link_if.front lk
);
  localparam int P_SCK = 0;
  localparam int P_CSB = 1;
  localparam int P_SDI = 2;
  localparam int P_UP  = 3;
  localparam int P_TOS = 4;

  logic [4:0] s1_r;
  logic [4:0] s2_r;
  logic       sck_d_r;
  logic       csb_d_r;

  // only s2_r and later stages feed logic
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      s1_r    <= `SMCD_PIN_IDLE;
      s2_r    <= `SMCD_PIN_IDLE;
      sck_d_r <= 1'b1;
      csb_d_r <= 1'b1;
    end else begin
      s1_r    <= {tos_i, sdo_up_i, sdi_i, csb_n_i, sck_i};
      s2_r    <= s1_r;
      sck_d_r <= s2_r[P_SCK];
      csb_d_r <= s2_r[P_CSB];
    end
  end

  assign lk.sck_lvl  = s2_r[P_SCK];
  assign lk.sck_rise = s2_r[P_SCK] & ~sck_d_r;
  assign lk.sck_fall = ~s2_r[P_SCK] & sck_d_r;
  assign lk.cs_act   = ~s2_r[P_CSB];
  assign lk.cs_rise  = s2_r[P_CSB] & ~csb_d_r;
  assign lk.sdi      = s2_r[P_SDI];
  assign lk.sdo_up   = s2_r[P_UP];
  assign lk.tos      = s2_r[P_TOS];
endmodule // smcd_link_sync

// file: rtl/smcd_top.sv
`timescale 1ns/1ps
`include "smcd_defines.svh"
module smcd_top
  import smcd_pkg::*;
#(
  parameter int          TOGGLE_HALF_CYC = `SMCD_TOGGLE_HALF_US *
                                           `SMCD_CLK_MHZ,
  parameter logic [7:0]  PEC_INIT        = `SMCD_CRC_INIT
) (
  input  wire logic        mclk_i,
  input  wire logic        rst_n_i,
  input  wire logic        sck_i,
  input  wire logic        chip_select_in_n_i,
  input  wire logic        sdi_i,
  input  wire logic        sdo_up_i,
  input  wire logic        tos_i,
  input  wire logic        conv_busy_i,
  input  wire logic        interrupt_i,
  input  wire logic        result_we_i,
  input  wire logic [3:0]  result_idx_i,
  input  wire logic [11:0] result_data_i,
  input  wire logic [23:0] flag_group_i,
  input  wire logic [39:0] temp_group_i,
  output logic             sdo_o,
  output logic             sck_up_o,
  output logic             csb_up_n_o,
  output logic             sdi_up_o,
  output logic             conv_start_o,
  output logic [7:0]       conv_cmd_o,
  output logic [47:0]      config_o,
  output logic [11:0]      discharge_o
);
  localparam int TW = $clog2(TOGGLE_HALF_CYC + 1);

  if (TOGGLE_HALF_CYC < 2) begin : g_chk
    $error("TOGGLE_HALF_CYC must be at least 2");
  end

  function automatic logic [7:0] crc_step(input logic [7:0] c,
                                          input logic       b);
    logic fb;
    fb = c[7] ^ b;
    crc_step = {c[6:0], 1'b0} ^ (fb ? `SMCD_CRC_POLY : 8'h00);
  endfunction

  function automatic logic [7:0] pat_byte(input smcd_tst_t t);
    pat_byte = (t == SMCD_T_PAT1) ? 8'(`SMCD_PAT1 >> 4) :
                                    8'(`SMCD_PAT2 >> 4);
  endfunction

  smcd_link_if lk ();

  smcd_link_sync u_sync (
    .mclk_i   (mclk_i),
    .rst_n_i  (rst_n_i),
    .sck_i    (sck_i),
    .csb_n_i  (chip_select_in_n_i),
    .sdi_i    (sdi_i),
    .sdo_up_i (sdo_up_i),
    .tos_i    (tos_i),
    .lk       (lk.front)
  );

  smcd_state_t state_r;
  smcd_state_t state_nxt;
  smcd_grp_t   grp_r;
  smcd_tst_t   tmp_tst_r;
  logic [7:0]  rx_sh_r;
  logic [2:0]  bit_cnt_r;
  logic [4:0]  byte_cnt_r;
  logic [7:0]  cmd_r;
  logic [4:0]  rd_len_r;
  logic [7:0]  tx_sh_r;
  logic [2:0]  tx_bit_r;
  logic [4:0]  tx_idx_r;
  logic        crc_on_r;
  logic        pass_r;
  logic [7:0]  crc_r;
  logic [7:0]  cfg_r [0:5];
  logic [7:0]  shd_r [0:5];
  logic [11:0] cell_r [0:`SMCD_NUM_CELLS-1];
  logic [TW-1:0] tog_cnt_r;
  logic        toggle_r;
  logic        no_dc_r;

  // command byte decode
  wire [7:0] rx_byte   = {rx_sh_r[6:0], lk.sdi};
  wire       byte_done = lk.sck_rise & lk.cs_act & (bit_cnt_r == 3'h7);
  wire       cmd_done  = byte_done & (state_r == SMCD_ST_IDLE);
  wire       ten_cell  = cfg_r[0][`SMCD_CFG_TEN_BIT];
  wire       level_pl  = cfg_r[0][`SMCD_CFG_LVL_BIT];
  wire [3:0] fam       = rx_byte[7:4];
  wire [3:0] sub       = rx_byte[3:0];
  wire       fam_dc    = (fam == `SMCD_FAM_CELL_DC) |
                         (fam == `SMCD_FAM_OW_DC);
  wire       fam_cell  = (fam == `SMCD_FAM_CELL) |
                         (fam == `SMCD_FAM_OW) | fam_dc;
  wire       fam_temp  = (fam == `SMCD_FAM_TEMP);
  wire       sub_test  = (sub == `SMCD_SUB_TEST1) |
                         (sub == `SMCD_SUB_TEST2);
  wire       cell_ok   = (sub != `SMCD_SUB_UNUSED) &
                         ~(ten_cell & ((sub == `SMCD_SUB_CELL11) |
                                       (sub == `SMCD_SUB_CELL12)));
  wire       temp_ok   = (sub <= `SMCD_SUB_TEMP_LAST) | sub_test;
  wire       conv_ok   = (fam_cell & cell_ok) | (fam_temp & temp_ok);
  wire       is_poll   = (rx_byte == `SMCD_CMD_POLL_ADC) |
                         (rx_byte == `SMCD_CMD_POLL_INT);
  wire       is_wr     = (rx_byte == `SMCD_CMD_WR_CFG);
  wire       is_rd     = (rx_byte == `SMCD_CMD_RD_CFG) |
                         (rx_byte == `SMCD_CMD_RD_CV) |
                         (rx_byte == `SMCD_CMD_RD_FLG) |
                         (rx_byte == `SMCD_CMD_RD_TMP);
  wire smcd_grp_t rd_grp =
    (rx_byte == `SMCD_CMD_RD_CFG) ? SMCD_G_CFG :
    (rx_byte == `SMCD_CMD_RD_CV)  ? SMCD_G_CV  :
    (rx_byte == `SMCD_CMD_RD_FLG) ? SMCD_G_FLG : SMCD_G_TMP;
  wire [4:0] rd_len =
    (rd_grp == SMCD_G_CFG) ? `SMCD_CFG_BYTES :
    (rd_grp == SMCD_G_FLG) ? `SMCD_FLG_BYTES :
    (rd_grp == SMCD_G_TMP) ? 5'(`SMCD_TMP_BYTES) :
    (ten_cell ? `SMCD_CV10_BYTES : `SMCD_CV_BYTES);
  wire smcd_tst_t conv_tst =
    (sub == `SMCD_SUB_TEST1) ? SMCD_T_PAT1 :
    (sub == `SMCD_SUB_TEST2) ? SMCD_T_PAT2 : SMCD_T_NONE;

  // group byte packing
  wire [7:0] cv_b  [0:17];
  wire [7:0] tmp_b [0:`SMCD_TMP_BYTES-1];
  for (genvar p = 0; p < `SMCD_NUM_PAIRS; p++) begin : g_cv
    assign cv_b[3*p]   = cell_r[2*p][`SMCD_CV_LO_BYTE];
    assign cv_b[3*p+1] = {cell_r[2*p+1][`SMCD_CV_LO_NIB],
                          cell_r[2*p][`SMCD_CV_HI_NIB]};
    assign cv_b[3*p+2] = cell_r[2*p+1][`SMCD_CV_HI_BYTE];
  end
  for (genvar i = 0; i < `SMCD_TMP_BYTES; i++) begin : g_tmp
    wire [7:0] raw = temp_group_i[8*i +: 8];
    wire [7:0] pat = pat_byte(tmp_tst_r);
    if (i == `SMCD_TMP_BYTES - 1) begin : g_last
      // top nibble is not a temperature field, left untouched
      assign tmp_b[i] = (tmp_tst_r == SMCD_T_NONE) ? raw :
                        {raw[`SMCD_TMP_KEEP], pat[3:0]};
    end else begin : g_body
      assign tmp_b[i] = (tmp_tst_r == SMCD_T_NONE) ? raw : pat;
    end
  end

  wire [7:0] tx_byte =
    (grp_r == SMCD_G_CFG) ? cfg_r[tx_idx_r[2:0]] :
    (grp_r == SMCD_G_CV)  ? cv_b[tx_idx_r] :
    (grp_r == SMCD_G_FLG) ? flag_group_i[{tx_idx_r[1:0], 3'h0} +: 8] :
                            tmp_b[tx_idx_r[2:0]];
  wire [7:0] tx_load  = (tx_idx_r < rd_len_r) ? tx_byte : crc_r;
  wire [4:0] len_p1   = 5'(rd_len_r + 5'd1);
  wire       own_rd   = (state_r == SMCD_ST_READ) &
                        (byte_cnt_r < len_p1);
  wire       own_wr   = (state_r == SMCD_ST_WRITE) &
                        (byte_cnt_r < `SMCD_CFG_BYTES);
  wire       poll_low = (cmd_r == `SMCD_CMD_POLL_INT) ? interrupt_i :
                                                       conv_busy_i;
  wire       poll_val = poll_low ? 1'b0 :
                        lk.tos   ? (level_pl | toggle_r) :
                                   lk.sdo_up;
  wire [11:0] dcc     = {cfg_r[2][`SMCD_DCC_HI], cfg_r[1]};

  // command sequencer
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      SMCD_ST_IDLE: begin
        if (cmd_done) begin
          if (is_wr)
            state_nxt = SMCD_ST_WRITE;
          else if (is_rd)
            state_nxt = SMCD_ST_READ;
          else if (conv_ok | is_poll)
            state_nxt = SMCD_ST_POLL;
          else
            state_nxt = SMCD_ST_SKIP;
        end
      end
      SMCD_ST_WRITE,
      SMCD_ST_READ,
      SMCD_ST_POLL,
      SMCD_ST_SKIP: state_nxt = state_r;
      default:      state_nxt = SMCD_ST_IDLE;
    endcase
    if (!lk.cs_act)
      state_nxt = SMCD_ST_IDLE;
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i)
      state_r <= SMCD_ST_IDLE;
    else
      state_r <= state_nxt;
  end

  // receive side: bits msb first on rising clock
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i || !lk.cs_act) begin
      rx_sh_r    <= 8'h00;
      bit_cnt_r  <= 3'h0;
      byte_cnt_r <= 5'h00;
    end else if (lk.sck_rise) begin
      rx_sh_r   <= rx_byte;
      bit_cnt_r <= 3'(bit_cnt_r + 3'h1);
      if (byte_done && state_r != SMCD_ST_IDLE && byte_cnt_r != 5'h1f)
        byte_cnt_r <= 5'(byte_cnt_r + 5'h01);
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      cmd_r    <= 8'h00;
      grp_r    <= SMCD_G_CFG;
      rd_len_r <= 5'h00;
    end else if (cmd_done) begin
      cmd_r    <= rx_byte;
      grp_r    <= rd_grp;
      rd_len_r <= rd_len; // length fixed for the whole read
    end
  end

  // configuration shadow and commit
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      for (int k = 0; k < 6; k++) begin
        cfg_r[k] <= `SMCD_CFG_RESET;
        shd_r[k] <= `SMCD_CFG_RESET;
      end
    end else begin
      if (byte_done && own_wr)
        shd_r[byte_cnt_r[2:0]] <= rx_byte;
      // partial writes are dropped, never half applied
      if (lk.cs_rise && state_r == SMCD_ST_WRITE &&
          byte_cnt_r >= `SMCD_CFG_BYTES)
        for (int k = 0; k < 6; k++)
          cfg_r[k] <= shd_r[k];
    end
  end

  // transmit side: change on falling clock
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i || state_r != SMCD_ST_READ) begin
      tx_sh_r  <= 8'hff;
      tx_bit_r <= 3'h0;
      tx_idx_r <= 5'h00;
      crc_on_r <= 1'b0;
      pass_r   <= 1'b0;
    end else if (lk.sck_fall) begin
      tx_bit_r <= 3'(tx_bit_r + 3'h1);
      if (tx_bit_r == 3'h0) begin
        tx_sh_r  <= {tx_load[6:0], 1'b1};
        crc_on_r <= (tx_idx_r < rd_len_r);
        pass_r   <= (tx_idx_r == len_p1);
        if (tx_idx_r != len_p1)
          tx_idx_r <= 5'(tx_idx_r + 5'h01);
      end else begin
        tx_sh_r <= {tx_sh_r[6:0], 1'b1};
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i || cmd_done)
      crc_r <= PEC_INIT;
    else if (lk.sck_rise && state_r == SMCD_ST_READ && crc_on_r)
      crc_r <= crc_step(crc_r, sdo_o);
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i)
      sdo_o <= 1'b1;
    else if (state_r == SMCD_ST_POLL)
      sdo_o <= poll_val;
    else if (state_r != SMCD_ST_READ)
      sdo_o <= 1'b1;
    else if (pass_r)
      sdo_o <= lk.sdo_up;
    else if (lk.sck_fall)
      sdo_o <= (tx_bit_r == 3'h0) ? tx_load[7] : tx_sh_r[7];
  end

  // upward chain: clock held idle while own bytes move
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      sck_up_o   <= 1'b1;
      csb_up_n_o <= 1'b1;
      sdi_up_o   <= 1'b1;
    end else begin
      sck_up_o   <= lk.sck_lvl | own_rd | own_wr;
      csb_up_n_o <= ~lk.cs_act;
      sdi_up_o   <= lk.sdi;
    end
  end

  // 1 kHz toggle for top-of-stack toggle polling
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      tog_cnt_r <= '0;
      toggle_r  <= 1'b0;
    end else if (tog_cnt_r == TW'(TOGGLE_HALF_CYC - 1)) begin
      tog_cnt_r <= '0;
      toggle_r  <= ~toggle_r;
    end else begin
      tog_cnt_r <= TW'(tog_cnt_r + 1'b1);
    end
  end

  // conversion launch
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      conv_start_o <= 1'b0;
      conv_cmd_o   <= 8'h00;
      no_dc_r      <= 1'b0;
      tmp_tst_r    <= SMCD_T_NONE;
    end else begin
      conv_start_o <= cmd_done & conv_ok;
      if (cmd_done && conv_ok) begin
        conv_cmd_o <= rx_byte;
        no_dc_r    <= fam_cell & ~fam_dc;
        if (fam_temp)
          tmp_tst_r <= conv_tst;
      end
    end
  end

  // cell results: converter writes, self tests overwrite all
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      for (int k = 0; k < `SMCD_NUM_CELLS; k++)
        cell_r[k] <= 12'h000;
    end else if (cmd_done && conv_ok && fam_cell && sub_test) begin
      for (int k = 0; k < `SMCD_NUM_CELLS; k++)
        cell_r[k] <= (conv_tst == SMCD_T_PAT1) ? `SMCD_PAT1 :
                                                 `SMCD_PAT2;
    end else if (result_we_i && result_idx_i < 4'(`SMCD_NUM_CELLS)) begin
      cell_r[result_idx_i] <= result_data_i;
    end
  end

  // discharge switches off during plain measurements
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i)
      discharge_o <= 12'h000;
    else
      discharge_o <= dcc & ~{12{conv_busy_i & no_dc_r}};
  end

  assign config_o = {cfg_r[5], cfg_r[4], cfg_r[3],
                     cfg_r[2], cfg_r[1], cfg_r[0]};
endmodule // smcd_top

// file: tb/smcd_monitor.sv
`timescale 1ns/1ps
module smcd_monitor #(
  parameter int         TOGGLE_HALF_CYC = 4,
  parameter logic [7:0] PEC_INIT        = 8'h00
) (
  input  wire logic        mclk_i,
  input  wire logic        rst_n_i,
  input  wire logic        chip_select_in_n_i,
  input  wire logic        conv_busy_i,
  input  wire logic        sdo_o,
  input  wire logic        conv_start_o,
  input  wire logic [7:0]  conv_cmd_o,
  input  wire logic [47:0] config_o,
  input  wire logic [11:0] discharge_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  wire logic [3:0]  fam     = conv_cmd_o[7:4];
  wire logic [3:0]  sub     = conv_cmd_o[3:0];
  wire logic [11:0] dis_cfg = {config_o[19:16], config_o[15:8]};
  wire logic        dc_fam  = fam == 4'h6 || fam == 4'h7;
  wire logic        blk_fam = fam == 4'h1 || fam == 4'h2;

  a_start_single: assert property (
    conv_start_o |=> !conv_start_o) else $error("start pulse too long");
  a_start_family: assert property (
    conv_start_o |-> fam inside {4'h1, 4'h2, 4'h3, 4'h6, 4'h7})
    else $error("start from a non conversion code");
  a_unused_sub: assert property (
    conv_start_o && fam != 4'h3 |-> sub != 4'hd)
    else $error("unused cell sub code started");
  a_temp_unused: assert property (
    conv_start_o && fam == 4'h3 |-> !(sub inside {[4'h4:4'hd]}))
    else $error("unused temperature code started");
  a_ten_cell_sub: assert property (
    conv_start_o && config_o[3] && fam != 4'h3
      |-> !(sub inside {4'hb, 4'hc}))
    else $error("cell 11 or 12 started in ten cell mode");
  // an update landing mid-frame would expose half-written bytes
  a_cfg_commit: assert property (
    !$stable(config_o) |-> $past(chip_select_in_n_i, 2))
    else $error("config changed while selected");
  a_dis_idle: assert property (
    !conv_busy_i && !$past(conv_busy_i) && $stable(config_o)
      |-> discharge_o == dis_cfg) else $error("discharge not from config");
  a_dis_keep: assert property (
    conv_busy_i && $past(conv_busy_i) && dc_fam && $stable(conv_cmd_o)
      && $stable(config_o) |-> discharge_o == dis_cfg)
    else $error("discharge dropped in permitted conversion");
  a_dis_block: assert property (
    conv_busy_i && $past(conv_busy_i) && blk_fam && $stable(conv_cmd_o)
      |-> discharge_o == 12'h000) else $error("discharge on in conversion");
  a_sdo_idle: assert property (
    chip_select_in_n_i [*6] |-> sdo_o) else $error("data out low when idle");

  c_start: cover property (conv_start_o);
  c_commit: cover property (!$stable(config_o));
  c_keep: cover property (conv_busy_i && dc_fam && discharge_o != 12'h000);
endmodule // smcd_monitor

bind smcd_top smcd_monitor #(
  .TOGGLE_HALF_CYC(TOGGLE_HALF_CYC),
  .PEC_INIT       (PEC_INIT)
) i_mon (
  .mclk_i            (mclk_i),
  .rst_n_i           (rst_n_i),
  .chip_select_in_n_i(chip_select_in_n_i),
  .conv_busy_i       (conv_busy_i),
  .sdo_o             (sdo_o),
  .conv_start_o      (conv_start_o),
  .conv_cmd_o        (conv_cmd_o),
  .config_o          (config_o),
  .discharge_o       (discharge_o)
);

// file: tb/smcd_host_model.sv
`timescale 1ns/1ps
module smcd_host_model (
  input  wire logic mclk_i,
  input  wire logic sdo_i,
  output logic      sck_o,
  output logic      csb_n_o,
  output logic      sdi_o
);
  initial begin
    sck_o   = 1'b1;
    csb_n_o = 1'b1;
    sdi_o   = 1'b1;
  end
  task automatic wait_n(input int n);
    repeat (n) @(negedge mclk_i);
  endtask
  // select moves only while the clock rests high
  task automatic sel(input logic lvl);
    wait_n(8);
    csb_n_o = lvl;
    if (lvl)
      sdi_o = 1'b1; // released data rests high
    wait_n(8);
  endtask
  // sample at the end of the high phase, well after the fall update
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      sck_o = 1'b0;
      sdi_o = tx[i];
      wait_n(4);
      sck_o = 1'b1;
      wait_n(4);
      rx[i] = sdo_i;
    end
  endtask
endmodule // smcd_host_model

// file: tb/stack_monitor_command_decoder_tb_top.sv
`timescale 1ns/1ps
module stack_monitor_command_decoder_tb_top;
  logic        mclk, rst_n, sck, csb_n, sdi, sdo_up, tos, busy, irq, we;
  logic        sdo, sck_up, csb_up_n, sdi_up, start, seen, sck_up_d;
  logic [3:0]  idx;
  logic [11:0] rdat, dis;
  logic [23:0] flg;
  logic [39:0] tmp;
  logic [47:0] cfg;
  logic [7:0]  cmd, rx, seen_cmd, up_byte;
  logic [7:0]  ex [0:17];
  logic [11:0] cv [0:11];
  logic [7:0]  codes [0:14] = '{8'h10, 8'h1a, 8'h1b, 8'h1c, 8'h1d, 8'h20,
    8'h2d, 8'h30, 8'h33, 8'h34, 8'h3d, 8'h60, 8'h7d, 8'h40, 8'h99};
  logic [47:0] w = 48'h7e81c3035a10;
  int          fail_count, check_count, cyc, up_cnt;

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  smcd_top #(.TOGGLE_HALF_CYC(4)) i_dut (
    .mclk_i(mclk), .rst_n_i(rst_n), .sck_i(sck), .chip_select_in_n_i(csb_n),
    .sdi_i(sdi), .sdo_up_i(sdo_up), .tos_i(tos), .conv_busy_i(busy),
    .interrupt_i(irq), .result_we_i(we), .result_idx_i(idx),
    .result_data_i(rdat), .flag_group_i(flg), .temp_group_i(tmp),
    .sdo_o(sdo), .sck_up_o(sck_up), .csb_up_n_o(csb_up_n),
    .sdi_up_o(sdi_up), .conv_start_o(start), .conv_cmd_o(cmd),
    .config_o(cfg), .discharge_o(dis));

  smcd_host_model i_host (.mclk_i(mclk), .sdo_i(sdo), .sck_o(sck),
    .csb_n_o(csb_n), .sdi_o(sdi));

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  always @(posedge mclk) begin
    cyc++;
    if (start === 1'b1) begin
      seen = 1'b1;
      seen_cmd = cmd;
    end
    if (cyc == 40000) begin
      fail_count++;
      wrap_up();
    end
  end

  // upward clock edges and the byte they carry
  always @(posedge mclk) begin
    sck_up_d <= sck_up;
    if (sck_up === 1'b1 && sck_up_d === 1'b0) begin
      up_cnt++;
      up_byte <= {up_byte[6:0], sdi_up};
    end
  end

  task automatic chk(input logic [63:0] s, input logic [63:0] e);
    check_count++;
    if (s !== e) begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  function automatic logic [7:0] crc(input int n);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 0; i < n; i++)
      for (int b = 7; b >= 0; b--)
        c = {c[6:0], 1'b0} ^ ((c[7] ^ ex[i][b]) ? 8'h07 : 8'h00);
    return c;
  endfunction

  function automatic logic legal(input logic [7:0] c, input logic ten);
    if (c[7:4] == 4'h3)
      return c[3:0] < 4'h4 || c[3:0] > 4'hd;
    if (c[7:4] inside {4'h1, 4'h2, 4'h6, 4'h7})
      return c[3:0] != 4'hd && !(ten && c[3:0] inside {4'hb, 4'hc});
    return 1'b0;
  endfunction

  task automatic cvex();
    for (int p = 0; p < 6; p++) begin
      ex[3*p]   = cv[2*p][7:0];
      ex[3*p+1] = {cv[2*p+1][3:0], cv[2*p][11:8]};
      ex[3*p+2] = cv[2*p+1][11:4];
    end
  endtask

  task automatic rd(input logic [7:0] c, input int n);
    i_host.sel(1'b0);
    i_host.xfer(c, rx);
    for (int i = 0; i < n; i++) begin
      i_host.xfer(8'h00, rx);
      chk(rx, ex[i]);
    end
    i_host.xfer(8'h00, rx);
    chk(rx, crc(n));
    sdo_up = 1'b1;
    i_host.xfer(8'h00, rx);
    chk(rx, 8'hff);
    sdo_up = 1'b0;
    i_host.sel(1'b1);
  endtask

  task automatic wr(input logic [47:0] v, input int n);
    up_cnt = 0;
    i_host.sel(1'b0);
    chk(csb_up_n, 1'b0);
    i_host.xfer(8'h01, rx);
    for (int i = 0; i < n; i++)
      i_host.xfer(v[8*i+:8], rx);
    i_host.xfer(8'ha5, rx);
    i_host.sel(1'b1);
    chk(csb_up_n, 1'b1);
    chk(up_cnt, (n < 6) ? 8 : 16);
    if (n == 6)
      chk(up_byte, 8'ha5);
  endtask

  task automatic go(input logic [7:0] c);
    seen = 1'b0;
    i_host.sel(1'b0);
    i_host.xfer(c, rx);
    i_host.sel(1'b1);
  endtask

  task automatic pat(input logic [7:0] c, input logic [11:0] v);
    go(c);
    for (int i = 0; i < 12; i++)
      cv[i] = v;
    cvex();
    rd(8'h04, 18);
  endtask

  initial begin
    {rst_n, sdo_up, busy, irq, we, idx, rdat, flg, tmp} = '0;
    tos = 1'b1;
    repeat (20) @(negedge mclk);
    rst_n = 1'b1;
    i_host.wait_n(4);
    chk(cfg, 48'h0);
    for (int i = 0; i < 18; i++)
      ex[i] = 8'h00;
    rd(8'h02, 6);
    wr(w, 6);
    chk(cfg, w);
    for (int i = 0; i < 6; i++)
      ex[i] = w[8*i+:8];
    rd(8'h02, 6);
    wr(48'hffffffffffff, 3);
    chk(cfg, w);
    for (int i = 0; i < 12; i++) begin
      cv[i] = 12'(i * 12'h137) ^ 12'h9a5;
      idx = 4'(i);
      rdat = cv[i];
      we = 1'b1;
      @(negedge mclk);
      we = 1'b0;
    end
    idx = 4'hc;
    rdat = 12'hfff;
    we = 1'b1;
    @(negedge mclk);
    we = 1'b0;
    cvex();
    rd(8'h04, 18);
    wr({w[47:8], 8'h18}, 6);
    rd(8'h04, 15);
    flg = 24'h3c5a96;
    tmp = 40'hc172e344b5;
    for (int i = 0; i < 5; i++)
      ex[i] = i < 3 ? flg[8*i+:8] : 8'h00;
    rd(8'h06, 3);
    for (int i = 0; i < 5; i++)
      ex[i] = tmp[8*i+:8];
    rd(8'h08, 5);
    go(8'h3e);
    ex = '{4: {tmp[39:36], 4'h5}, default: 8'h55};
    rd(8'h08, 5);
    for (int t = 0; t < 2; t++) begin
      wr({w[47:8], t ? 8'h10 : 8'h18}, 6);
      for (int j = 0; j < 15; j++) begin
        go(codes[j]);
        chk(seen, legal(codes[j], t == 0));
        if (seen === 1'b1)
          chk(seen_cmd, codes[j]);
      end
    end
    pat(8'h1e, 12'h555);
    pat(8'h2f, 12'haaa);
    pat(8'h7e, 12'h555);
    i_host.sel(1'b0);
    i_host.xfer(8'h10, rx);
    busy = 1'b1;
    i_host.wait_n(8);
    chk(sdo, 1'b0);
    chk(dis, 12'h000);
    busy = 1'b0;
    i_host.wait_n(8);
    chk(sdo, 1'b1);
    tos = 1'b0;
    i_host.wait_n(8);
    chk(sdo, 1'b0);
    sdo_up = 1'b1;
    i_host.wait_n(8);
    chk(sdo, 1'b1);
    sdo_up = 1'b0;
    tos = 1'b1;
    i_host.sel(1'b1);
    i_host.sel(1'b0);
    i_host.xfer(8'h60, rx);
    busy = 1'b1;
    i_host.wait_n(8);
    chk(dis, 12'h35a);
    busy = 1'b0;
    i_host.sel(1'b1);
    i_host.sel(1'b0);
    i_host.xfer(8'h50, rx);
    irq = 1'b1;
    i_host.wait_n(8);
    chk(sdo, 1'b0);
    irq = 1'b0;
    i_host.sel(1'b1);
    busy = 1'b1;
    i_host.wait_n(8);
    chk(sdo, 1'b1);
    busy = 1'b0;
    wr({w[47:8], 8'h00}, 6);
    i_host.sel(1'b0);
    i_host.xfer(8'h40, rx);
    i_host.wait_n(8);
    seen = sdo;
    i_host.wait_n(4);
    chk(sdo ^ seen, 1'b1);
    i_host.sel(1'b1);
    wrap_up();
  end
endmodule // stack_monitor_command_decoder_tb_top
